// *** shared/conv_ctrl_pkg.sv ***
// Package: register map, field positions, reset values and types of the converter control block
package conv_ctrl_pkg;

	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int RESULT_W   = 12;
	localparam int BUSWORD_W  = 16;
	localparam int NUM_PINS   = 16;
	localparam int NUM_BUF    = 16;
	localparam int CHSEL_W    = 4;

	// ----------------------------------------
	// Register byte offsets
	// ----------------------------------------
	localparam logic [11:0] OFF_CONTROL    = 12'h000;
	localparam logic [11:0] OFF_CHANNEL    = 12'h004;
	localparam logic [11:0] OFF_PIN_CFG    = 12'h008;
	localparam logic [11:0] OFF_PIN_DIR    = 12'h00C;
	localparam logic [11:0] OFF_PORT_OUT   = 12'h010;
	localparam logic [11:0] OFF_PORT_READ  = 12'h014;
	localparam logic [11:0] OFF_STATUS     = 12'h018;
	localparam logic [11:0] OFF_BUF_BASE   = 12'h040;
	localparam logic [11:0] OFF_BUF_END    = 12'h07C;

	// ----------------------------------------
	// Control and channel register fields
	// ----------------------------------------
	localparam int CTL_ON_BIT        = 15;
	localparam int CTL_SIDL_BIT      = 13;
	localparam int CTL_FORM_LSB      = 8;
	localparam int CTL_START_BIT     = 1;
	localparam int CTL_AUTO_BIT      = 2;
	localparam int CHN_SELB_LSB      = 8;
	localparam int CHN_ALT_BIT       = 0;
	localparam int CHN_SELA_LSB      = 4;

	// ----------------------------------------
	// Reset values and timing
	// ----------------------------------------
	localparam logic [15:0] RST_PIN_CFG = 16'h0000;
	localparam logic [15:0] RST_PIN_DIR = 16'hFFFF;
	localparam logic [15:0] RST_ZERO16  = 16'h0000;
	localparam logic [4:0]  SAMPLE_CYCLES  = 5'h04;
	localparam logic [4:0]  CONVERT_CYCLES = 5'h0E;

	typedef enum logic [1:0] {
		FMT_INTEGER    = 2'h0,
		FMT_SIGNED_INT = 2'h1,
		FMT_FRACTIONAL = 2'h2,
		FMT_SIGNED_FRAC = 2'h3
	} output_format_type;

	typedef struct packed {
		logic                      converter_on;
		logic                      stop_in_idle_select;
		output_format_type         output_format_select;
		logic                      auto_repeat;
		logic [CHSEL_W-1:0]        channel_select_a;
		logic [CHSEL_W-1:0]        channel_select_b;
		logic                      alternate;
	} control_type;

	typedef struct packed {
		logic                      valid;
		logic [3:0]                slot;
		logic [RESULT_W-1:0]       data;
	} result_write_type;

endpackage

// *** design/result_formatter.sv ***
// Result formatter: turns a stored 12-bit result into a 16-bit bus word
`timescale 1ns/1ps
module result_formatter
	import conv_ctrl_pkg::*;
(
	input  wire logic [RESULT_W-1:0]  raw,
	input  wire output_format_type    fmt,
	output logic [BUSWORD_W-1:0]      word
);

	always_comb begin
		unique case (fmt)
			FMT_INTEGER:     word = {4'h0, raw}; // [R10]
			FMT_SIGNED_INT:  word = {{4{raw[RESULT_W-1]}}, raw}; // [R9]
			FMT_FRACTIONAL:  word = {raw, 4'h0}; // [R8]
			FMT_SIGNED_FRAC: word = {raw, 4'h0}; // [R8]
		endcase
	end

endmodule

// *** design/pin_sync.sv ***
// Pin synchroniser: three stage flops and an output flop, a change counts once the last two stages agree
`timescale 1ns/1ps
module pin_sync
	import conv_ctrl_pkg::*;
(
	input  wire logic clk,
	input  wire logic srst,
	input  wire logic ce,
	input  wire logic pin_async,
	output logic      pin_level
);

	logic stage1;
	logic stage2;
	logic stage3;
	logic next_level;

	always_comb begin
		next_level = (stage2 == stage3) ? stage3 : pin_level;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			stage1    <= 1'b0;
			stage2    <= 1'b0;
			stage3    <= 1'b0;
			pin_level <= 1'b0;
		end else if (ce) begin
			stage1    <= pin_async;
			stage2    <= stage1;
			stage3    <= stage2;
			pin_level <= next_level;
		end
	end

endmodule

// *** design/conv_ctrl.sv ***
// Converter control: APB registers, result buffer, format, pin gating and conversion sequencing
`timescale 1ns/1ps
// Operation
// [R1] Stop-in-idle zero: keep converting during idle
// [R2] Stop-in-idle one: halt while CPU idles
// [R3] Reset clears registers, switches off, aborts; pin direction resets to all ones (16'hFFFF), not zero
// [R4] Reset leaves result buffer contents alone
// [R5] Buffer undefined after power-on, no init
// [R6] 12-bit results, 16-bit bus reads
// [R7] Two-bit field picks one of four formats
// [R8] Fractional formats: left-justified, low nibble zero
// [R9] Signed integer: right-justified, sign extended
// [R10] Integer: right-justified, upper nibble zero
// [R11] Pin config and direction pick analog inputs
// [R12] Output-driven analog pin converts driven level
// [R13] Operation independent of channel select, direction
// [R14] Port reads zero on analog channel pins
// [R15] Digital-input pins supply no analog level
// [R16] Converter off disables digital and analog
// [R17] Format codes: 00 int, 01 sint, 10 frac, 11 sfrac
module conv_ctrl
	import conv_ctrl_pkg::*;
(
	input  wire logic                   clk,
	input  wire logic                   srst,
	input  wire logic                   ce,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [11:0]            paddr,
	input  wire logic [31:0]            pwdata,
	output logic                        pready,
	output logic [31:0]                 prdata,
	output logic                        pslverr,
	input  wire logic                   cpu_idle,
	input  wire logic [NUM_PINS-1:0]    pin_in,
	input  wire logic [RESULT_W-1:0]    analog_level,
	output logic [NUM_PINS-1:0]         pin_out,
	output logic [NUM_PINS-1:0]         pin_oe,
	output logic [CHSEL_W-1:0]          mux_channel,
	output logic                        analog_enable,
	output logic                        sample_active,
	output logic                        convert_active
);

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [NUM_PINS-1:0] pin_sync_level;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
			pin_sync u_sync (
				.clk       (clk),
				.srst      (srst),
				.ce        (ce),
				.pin_async (pin_in[gi]),
				.pin_level (pin_sync_level[gi])
			);
		end
	endgenerate

	// ----------------------------------------
	// Registers and state
	// ----------------------------------------
	typedef enum logic [1:0] {ST_OFF, ST_IDLE, ST_SAMPLE, ST_CONVERT} seq_state_type;

	control_type             ctl;
	control_type             next_ctl;
	logic [NUM_PINS-1:0]     analog_pin_config;
	logic [NUM_PINS-1:0]     next_analog_pin_config;
	logic [NUM_PINS-1:0]     pin_direction;
	logic [NUM_PINS-1:0]     next_pin_direction;
	logic [NUM_PINS-1:0]     port_latch;
	logic [NUM_PINS-1:0]     next_port_latch;
	logic                    start_req;
	logic                    next_start_req;
	seq_state_type           state;
	seq_state_type           next_state;
	logic [4:0]              count;
	logic [4:0]              next_count;
	logic [3:0]              wr_slot;
	logic [3:0]              next_wr_slot;
	logic                    done_flag;
	logic                    next_done_flag;
	logic [RESULT_W-1:0]     held_sample;
	logic [RESULT_W-1:0]     next_held_sample;
	result_write_type        buf_wr;

	// Result buffer has no reset: it keeps its words across device reset
	logic [RESULT_W-1:0]     result_buffer [NUM_BUF]; // [R6]

	// ----------------------------------------
	// APB decode
	// ----------------------------------------
	logic                    access;
	logic                    wr_en;
	logic                    rd_en;
	logic                    buf_hit;
	logic [3:0]              buf_index;
	logic                    mapped;

	assign access    = psel & penable & ~pready;
	assign wr_en     = access & pwrite;
	assign rd_en     = access & ~pwrite;
	assign buf_hit   = (paddr >= OFF_BUF_BASE) && (paddr <= OFF_BUF_END) && (paddr[1:0] == 2'h0);
	assign buf_index = paddr[5:2];

	always_comb begin
		unique case (paddr)
			OFF_CONTROL, OFF_CHANNEL, OFF_PIN_CFG, OFF_PIN_DIR,
			OFF_PORT_OUT, OFF_PORT_READ, OFF_STATUS: mapped = 1'b1;
			default:                                 mapped = buf_hit;
		endcase
	end

	// ----------------------------------------
	// Analog pin selection
	// ----------------------------------------
	logic [CHSEL_W-1:0]      active_channel;
	logic                    channel_is_analog;
	logic                    channel_is_output;
	logic [RESULT_W-1:0]     driven_level;
	logic [NUM_PINS-1:0]     port_view;

	assign active_channel    = ctl.alternate ? ctl.channel_select_b : ctl.channel_select_a;
	// Config bit zero means analog, matching a reset state of all analog
	assign channel_is_analog = ~analog_pin_config[active_channel]; // [R11]
	assign channel_is_output = ~pin_direction[active_channel];
	assign driven_level      = {RESULT_W{port_latch[active_channel]}};
	assign port_view         = pin_sync_level & analog_pin_config; // [R14]

	logic run_ok;
	// Sequencer runs regardless of channel selection or direction bits
	assign run_ok = ctl.converter_on & ~(ctl.stop_in_idle_select & cpu_idle); // [R1] [R2] [R13] [R16]

	// ----------------------------------------
	// Register next values
	// ----------------------------------------
	always_comb begin
		next_ctl               = ctl;
		next_analog_pin_config = analog_pin_config;
		next_pin_direction     = pin_direction;
		next_port_latch        = port_latch;
		next_start_req         = start_req;
		if (wr_en) begin
			unique case (paddr)
				OFF_CONTROL: begin
					next_ctl.converter_on         = pwdata[CTL_ON_BIT];
					next_ctl.stop_in_idle_select  = pwdata[CTL_SIDL_BIT];
					next_ctl.output_format_select = output_format_type'(pwdata[CTL_FORM_LSB +: 2]); // [R7] [R17]
					next_ctl.auto_repeat          = pwdata[CTL_AUTO_BIT];
					next_start_req                = pwdata[CTL_START_BIT];
				end
				OFF_CHANNEL: begin
					next_ctl.channel_select_b = pwdata[CHN_SELB_LSB +: CHSEL_W];
					next_ctl.channel_select_a = pwdata[CHN_SELA_LSB +: CHSEL_W];
					next_ctl.alternate        = pwdata[CHN_ALT_BIT];
				end
				OFF_PIN_CFG:  next_analog_pin_config = pwdata[NUM_PINS-1:0];
				OFF_PIN_DIR:  next_pin_direction     = pwdata[NUM_PINS-1:0];
				OFF_PORT_OUT: next_port_latch        = pwdata[NUM_PINS-1:0];
				default: ;
			endcase
		end
		if (state == ST_SAMPLE) begin
			next_start_req = 1'b0;
		end
	end

	// ----------------------------------------
	// Conversion sequencer
	// ----------------------------------------
	always_comb begin
		next_state       = state;
		next_count       = count;
		next_wr_slot     = wr_slot;
		next_done_flag   = done_flag;
		next_held_sample = held_sample;
		buf_wr           = '0;
		if (!ctl.converter_on) begin
			next_state = ST_OFF; // [R16]
		end else if (run_ok) begin
			unique case (state)
				ST_OFF: next_state = ST_IDLE;
				ST_IDLE: begin
					if (start_req || ctl.auto_repeat) begin
						next_state     = ST_SAMPLE;
						next_count     = SAMPLE_CYCLES;
						next_done_flag = 1'b0;
					end
				end
				ST_SAMPLE: begin
					if (count == 5'h01) begin
						next_state = ST_CONVERT;
						next_count = CONVERT_CYCLES;
						// Digital pins hand over zero, analog output pins their own drive
						if (!channel_is_analog) begin
							next_held_sample = '0; // [R15]
						end else if (channel_is_output) begin
							next_held_sample = driven_level; // [R12]
						end else begin
							next_held_sample = analog_level;
						end
					end else begin
						next_count = count - 5'h01;
					end
				end
				ST_CONVERT: begin
					if (count == 5'h01) begin
						next_state     = ST_IDLE;
						next_done_flag = 1'b1;
						next_wr_slot   = wr_slot + 4'h1;
						buf_wr.valid   = 1'b1;
						buf_wr.slot    = wr_slot;
						buf_wr.data    = held_sample;
					end else begin
						next_count = count - 5'h01;
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	logic [BUSWORD_W-1:0] formatted;
	logic [31:0]          next_prdata;

	result_formatter u_fmt (
		.raw  (result_buffer[buf_index]),
		.fmt  (ctl.output_format_select),
		.word (formatted)
	);

	always_comb begin
		next_prdata = 32'h0000_0000;
		if (rd_en) begin
			unique case (paddr)
				OFF_CONTROL: begin
					next_prdata[CTL_ON_BIT]             = ctl.converter_on;
					next_prdata[CTL_SIDL_BIT]           = ctl.stop_in_idle_select;
					next_prdata[CTL_FORM_LSB +: 2]      = ctl.output_format_select;
					next_prdata[CTL_AUTO_BIT]           = ctl.auto_repeat;
					next_prdata[CTL_START_BIT]          = start_req;
				end
				OFF_CHANNEL: begin
					next_prdata[CHN_SELB_LSB +: CHSEL_W] = ctl.channel_select_b;
					next_prdata[CHN_SELA_LSB +: CHSEL_W] = ctl.channel_select_a;
					next_prdata[CHN_ALT_BIT]             = ctl.alternate;
				end
				OFF_PIN_CFG:   next_prdata[NUM_PINS-1:0] = analog_pin_config;
				OFF_PIN_DIR:   next_prdata[NUM_PINS-1:0] = pin_direction;
				OFF_PORT_OUT:  next_prdata[NUM_PINS-1:0] = port_latch;
				OFF_PORT_READ: next_prdata[NUM_PINS-1:0] = port_view; // [R14]
				OFF_STATUS:    next_prdata[3:0] = {wr_slot == 4'h0, done_flag,
					state == ST_CONVERT, state == ST_SAMPLE};
				default: begin
					if (buf_hit) begin
						next_prdata[BUSWORD_W-1:0] = formatted; // [R6]
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// Flops
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			ctl               <= '0; // [R3]
			analog_pin_config <= RST_PIN_CFG;
			pin_direction     <= RST_PIN_DIR;
			port_latch        <= RST_ZERO16;
			start_req         <= 1'b0;
			state             <= ST_OFF; // [R3]
			count             <= 5'h00;
			wr_slot           <= 4'h0;
			done_flag         <= 1'b0;
			held_sample       <= '0;
			pready            <= 1'b0;
			prdata            <= 32'h0000_0000;
			pslverr           <= 1'b0;
			pin_out           <= RST_ZERO16;
			pin_oe            <= RST_ZERO16;
			mux_channel       <= '0;
			analog_enable     <= 1'b0;
			sample_active     <= 1'b0;
			convert_active    <= 1'b0;
		end else if (ce) begin
			ctl               <= next_ctl;
			analog_pin_config <= next_analog_pin_config;
			pin_direction     <= next_pin_direction;
			port_latch        <= next_port_latch;
			start_req         <= next_start_req;
			state             <= next_state;
			count             <= next_count;
			wr_slot           <= next_wr_slot;
			done_flag         <= next_done_flag;
			held_sample       <= next_held_sample;
			pready            <= access;
			prdata            <= next_prdata;
			pslverr           <= access & ~mapped;
			pin_out           <= next_port_latch;
			pin_oe            <= ~next_pin_direction;
			mux_channel       <= active_channel;
			analog_enable     <= next_ctl.converter_on; // [R16]
			sample_active     <= (next_state == ST_SAMPLE);
			convert_active    <= (next_state == ST_CONVERT);
		end
	end

	// No reset branch: words survive reset and start undefined at power-on
	always_ff @(posedge clk) begin
		if (ce && buf_wr.valid) begin
			result_buffer[buf_wr.slot] <= buf_wr.data; // [R4] [R5]
		end
	end

endmodule

// *** verification/conv_ctrl_assertions.sv ***
// Checker: timing and format relations at the converter control ports
`timescale 1ns/1ps
module conv_ctrl_assertions
	import conv_ctrl_pkg::*;
(
	input wire logic                clk,
	input wire logic                srst,
	input wire logic                ce,
	input wire logic                psel,
	input wire logic                penable,
	input wire logic                pwrite,
	input wire logic [11:0]         paddr,
	input wire logic [31:0]         pwdata,
	input wire logic                pready,
	input wire logic [31:0]         prdata,
	input wire logic                pslverr,
	input wire logic                cpu_idle,
	input wire logic [NUM_PINS-1:0] pin_in,
	input wire logic [RESULT_W-1:0] analog_level,
	input wire logic [NUM_PINS-1:0] pin_out,
	input wire logic [NUM_PINS-1:0] pin_oe,
	input wire logic [CHSEL_W-1:0]  mux_channel,
	input wire logic                analog_enable,
	input wire logic                sample_active,
	input wire logic                convert_active
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	// ----
	// Helper state
	// ----
	logic [1:0] form_q;
	logic       sidl_q;
	logic [4:0] s_cnt;
	logic [4:0] c_cnt;
	logic       buf_rd;
	assign buf_rd = pready && !pwrite && !pslverr && paddr >= OFF_BUF_BASE && paddr <= OFF_BUF_END;
	// Phase lengths counted here since a repetition of 14 would be too long
	always_ff @(posedge clk) begin
		if (srst) begin
			form_q <= 2'h0;
			sidl_q <= 1'b0;
			s_cnt <= 5'h00;
			c_cnt <= 5'h00;
		end else if (ce) begin
			// Counters follow the design's enable, so a frozen phase is not overcounted
			if (psel && penable && pwrite && !pready && paddr == OFF_CONTROL) begin
				form_q <= pwdata[CTL_FORM_LSB +: 2];
				sidl_q <= pwdata[CTL_SIDL_BIT];
			end
			s_cnt <= sample_active ? s_cnt + 5'h01 : 5'h00;
			c_cnt <= convert_active ? c_cnt + 5'h01 : 5'h00;
		end
	end
	// ----
	// Properties
	// ----
	a_reset_off: assert property (disable iff (1'b0) srst && ce |=>
		!analog_enable && !sample_active && !convert_active && pin_oe == 16'h0000)
		else $error("converter active after reset");
	a_off_quiet: assert property (!analog_enable ##1 !analog_enable |->
		!sample_active && !convert_active) else $error("activity while off");
	a_ready_wait: assert property (psel && penable && !pready && ce |=> pready)
		else $error("answer not one cycle after request");
	a_upper_zero: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000)
		else $error("read word wider than 16 bits");
	a_fmt_int: assert property (buf_rd && form_q == FMT_INTEGER |-> prdata[15:12] == 4'h0)
		else $error("integer upper nibble not zero");
	a_fmt_sint: assert property (buf_rd && form_q == FMT_SIGNED_INT |->
		prdata[15:12] == {4{prdata[11]}}) else $error("signed integer not sign extended");
	a_fmt_frac: assert property (buf_rd && form_q[1] |-> prdata[3:0] == 4'h0)
		else $error("fractional low nibble not zero");
	a_sample_len: assert property ($fell(sample_active) && analog_enable |->
		s_cnt == SAMPLE_CYCLES && convert_active) else $error("sampling length wrong");
	a_convert_len: assert property ($fell(convert_active) && analog_enable |->
		c_cnt == CONVERT_CYCLES) else $error("conversion length wrong");
	a_idle_freeze: assert property (sidl_q && cpu_idle && analog_enable && !psel |=>
		$stable(sample_active) && $stable(convert_active)) else $error("sequencer moved while idle");
endmodule

bind conv_ctrl conv_ctrl_assertions i_chk (.clk(clk), .srst(srst), .ce(ce), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.prdata(prdata), .pslverr(pslverr), .cpu_idle(cpu_idle), .pin_in(pin_in),
	.analog_level(analog_level), .pin_out(pin_out), .pin_oe(pin_oe), .mux_channel(mux_channel),
	.analog_enable(analog_enable), .sample_active(sample_active), .convert_active(convert_active));

// *** verification/conv_ctrl_tb.sv ***
// Testbench: registers, formats, pin gating and sequencing of converter control
`timescale 1ns/1ps
module conv_ctrl_tb
	import conv_ctrl_pkg::*;
;
	typedef struct packed {
		logic [32:0] m;
		logic [32:0] e;
	} note_type;
	logic        clk, srst, ce, psel, penable, pwrite, cpu_idle;
	logic        pready, pslverr, analog_enable, sample_active, convert_active;
	logic [11:0] paddr, analog_level, lv;
	logic [31:0] pwdata, prdata;
	logic [15:0] pin_in, pin_out, pin_oe;
	logic [3:0]  mux_channel;
	logic [11:0] exp_buf [16];
	note_type    notes [$];
	note_type    nt;
	int          n_fail, samples_checked, cycles, slot;

	conv_ctrl i_dut (.clk(clk), .srst(srst), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .cpu_idle(cpu_idle), .pin_in(pin_in), .analog_level(analog_level),
		.pin_out(pin_out), .pin_oe(pin_oe), .mux_channel(mux_channel),
		.analog_enable(analog_enable), .sample_active(sample_active), .convert_active(convert_active));

	always #2 clk = ~clk;

	// ----
	// Result watcher and timeout
	// ----
	always @(posedge clk) begin
		cycles++;
		if (cycles == 30000) begin
			n_fail++;
			$display("wrong value at %0t: run did not finish", $time);
			conclude();
		end else if (pready === 1'b1) begin
			nt = notes.pop_front();
			if (nt.m != 33'h0) begin
				samples_checked++;
				if (({pslverr, prdata} & nt.m) !== (nt.e & nt.m)) begin
					n_fail++;
					$display("wrong value at %0t: read %h at %h, expected %h", $time, prdata, paddr, nt.e);
				end
			end
		end
	end

	// ----
	// Bus and sequence tasks
	// ----
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [32:0] m, input logic [32:0] e);
		notes.push_back('{m, e});
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, {1'b1, 32'h0}, 33'h0);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
		apb(1'b0, a, 32'h0, {1'b1, m}, {1'b0, e});
	endtask

	// Direct look at a pin-side output that stands until the next register write
	task automatic look(input logic [15:0] got, input logic [15:0] want);
		samples_checked++;
		if (got !== want) begin
			n_fail++;
			$display("wrong value at %0t: pin side %h, expected %h", $time, got, want);
		end
	endtask

	function automatic logic [31:0] ctl(input logic [1:0] f, input logic sidl, input logic st);
		ctl = 32'h0;
		ctl[CTL_ON_BIT] = 1'b1;
		ctl[CTL_SIDL_BIT] = sidl;
		ctl[CTL_FORM_LSB +: 2] = f;
		ctl[CTL_START_BIT] = st;
	endfunction

	function automatic logic [31:0] fmtw(input logic [11:0] r, input logic [1:0] f);
		case (f)
			2'h0: fmtw = {20'h0, r};
			2'h1: fmtw = {16'h0, {4{r[11]}}, r};
			default: fmtw = {16'h0, r, 4'h0};
		endcase
	endfunction

	// Idle is released here when stop-in-idle is set, else the run would hang
	task automatic convert(input logic [11:0] lvl, input logic [11:0] got, input logic sidl);
		int k;
		k = 0;
		analog_level <= lvl;
		exp_buf[slot] = got;
		wr(OFF_CONTROL, ctl(2'h0, sidl, 1'b0));
		wr(OFF_CONTROL, ctl(2'h0, sidl, 1'b1));
		if (sidl) begin
			// Short wait: a sequencer that ignored idle would still be busy here
			repeat (8) @(posedge clk);
			rd(OFF_STATUS, 32'h0, 32'h3);
			cpu_idle <= 1'b0;
		end
		while (convert_active !== 1'b1 && k < 200) begin
			@(posedge clk);
			k++;
		end
		while (convert_active === 1'b1 && k < 200) begin
			@(posedge clk);
			k++;
		end
		if (k >= 200) begin
			n_fail++;
			$display("wrong value at %0t: conversion did not complete", $time);
		end
		repeat (2) @(posedge clk);
		rd(OFF_BUF_BASE + 12'(4 * slot), fmtw(got, 2'h0), 32'hFFFF);
		slot++;
	endtask

	task automatic conclude;
		$display("checks %0d, mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// ----
	// Main sequence
	// ----
	initial begin
		clk = 1'b0;
		srst = 1'b1;
		ce = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		cpu_idle = 1'b0;
		pin_in = 16'h0000;
		analog_level = 12'h000;
		void'($urandom(32'hD277));
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		rd(OFF_CONTROL, 32'h0, 32'hFFFFFFFF);
		rd(OFF_PIN_DIR, {16'h0, RST_PIN_DIR}, 32'hFFFFFFFF);
		rd(OFF_PIN_CFG, {16'h0, RST_PIN_CFG}, 32'hFFFFFFFF);
		apb(1'b0, 12'h030, 32'h0, {1'b1, 32'hFFFFFFFF}, {1'b1, 32'h0});
		pin_in <= 16'($urandom);
		repeat (6) @(posedge clk);
		rd(OFF_PORT_READ, 32'h0, 32'hFFFFFFFF);
		wr(OFF_PIN_CFG, 32'h0000FF00);
		repeat (6) @(posedge clk);
		rd(OFF_PORT_READ, {16'h0, pin_in & 16'hFF00}, 32'hFFFFFFFF);
		for (int f = 0; f < 4; f++) begin
			lv = 12'($urandom);
			lv[11] = f[0];
			convert(lv, lv, 1'b0);
			for (int g = 0; g < 4; g++) begin
				wr(OFF_CONTROL, ctl(2'(g), 1'b0, 1'b0));
				rd(OFF_BUF_BASE + 12'(4 * (slot - 1)), fmtw(lv, 2'(g)), 32'hFFFF);
			end
		end
		cpu_idle <= 1'b1;
		lv = 12'($urandom);
		convert(lv, lv, 1'b0);
		convert(~lv, ~lv, 1'b1);
		wr(OFF_PIN_DIR, 32'h0000FFFE);
		for (int b = 0; b < 2; b++) begin
			wr(OFF_PORT_OUT, 32'(b));
			look(pin_out, 16'(b));
			look(pin_oe, 16'h0001);
			convert(12'h5A5, b ? 12'hFFF : 12'h000, 1'b0);
		end
		wr(OFF_CHANNEL, 32'h00000080);
		convert(12'h7C3, 12'h000, 1'b0);
		look(16'(mux_channel), 16'h0008);
		// Reset in mid-conversion: no write, old words kept
		analog_level <= 12'h123;
		wr(OFF_CONTROL, ctl(2'h0, 1'b0, 1'b1));
		repeat (8) @(posedge clk);
		srst <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		rd(OFF_CONTROL, 32'h0, 32'hFFFFFFFF);
		rd(OFF_STATUS, 32'h0, 32'h3);
		for (int i = 0; i < slot; i++)
			rd(OFF_BUF_BASE + 12'(4 * i), {20'h0, exp_buf[i]}, 32'hFFFF);
		conclude();
	end
endmodule
